// >>> hdl/cond_regs.vh
// Contract
// - Two-coil builds offer offset, bipolar, and half-supply ratiometric current and voltage ranges.
// - After reset the range is bipolar ten volts, zero to ten volts single-coil.
// - Out-of-range command raises error, then holds last valid value or cuts current.
// - Mismatched range setting reports error and never drives beyond the allowed range.
// - Single-coil builds allow inversion only for bipolar current and voltage types.
// - Two-coil builds negate the command when inversion is on, swapping coils.
// - Commands inside the dead band around zero give a zero setpoint.
// - Optional nine-point piecewise-linear curve, identity at quarter steps by default.
// - Gain is above zero and at most four; the 11-bit register is not clamped, so gains up to 2047/256 pass.
// - A configurable offset shifts the characteristic to cover spool overlap.
// - Ramp times run from zero to forty-five seconds.
// - Rise time is zero to full scale for a full step, smaller steps proportional.
// - Descent time is full scale to zero for a full downward step.
// - Rise and descent times are kept apart for positive and negative halves.
// - Offset-centred types command motion at zero raw input.
// - Ratiometric types centre on half the supply, span ten or five volts.
// - Edited settings act only after a save command commits them; the interrupt mask here takes effect as soon as it is written.
`ifndef COND_REGS_VH
`define COND_REGS_VH
// ****************************************
// Timing
// ****************************************
`define CLK_NS 100
`define RAMP_UNIT_NS 100000000
`define RAMP_MAX 9'h1C2
// ****************************************
// Register map
// ****************************************
`define A_CTRL 8'h00
`define A_CFG 8'h04
`define A_DBAND 8'h08
`define A_GAIN 8'h0C
`define A_OFFS 8'h10
`define A_RISE_P 8'h14
`define A_FALL_P 8'h18
`define A_RISE_N 8'h1C
`define A_FALL_N 8'h20
`define A_STAT 8'h24
`define A_ISTAT 8'h28
`define A_IMASK 8'h2C
`define A_SETP 8'h30
`define A_NORM 8'h34
`define BPX_PAGE 2'h1
`define BPY_PAGE 2'h2
`define CTRL_SAVE 0
`define CFG_MSB 6
`define TYPE_MSB 3
`define CFG_INV 4
`define CFG_LIN 5
`define CFG_SHUT 6
`define CFG_RST 7'h04
`define GAIN_RST 11'h100
`define GAIN_FRAC 8
`define NBP 9
`define BP_FIRST 16'hC000
`define IRQ_W 3
// ****************************************
// Input types and scaling
// ****************************************
`define T_0_20MA 4'h0
`define T_4_20MA 4'h1
`define T_PM10MA 4'h2
`define T_0_10V 4'h3
`define T_PM10V 4'h4
`define T_RAT10 4'h5
`define T_RAT5 4'h6
`define T_0_5V 4'h7
`define T_LAST 4'h7
`define U10K 16'h2710
`define U12K 16'h2EE0
`define U8K 16'h1F40
`define U5K 16'h1388
`define U2K5 16'h09C4
`define R10K 20'h1A36E
`define R8K 20'h20C4A
`define R5K 20'h346DC
`define R2K5 20'h68DB9
`define FS 22'sh004000
`define TOL 22'sh000148
`define RND_HALF 39'sh000008000
`define RSTEP 33'h000004000
`endif

// >>> hdl/seg_divider.v
`include "cond_regs.vh"
`default_nettype none

module seg_divider #(
  parameter NW = 39, // Dividend width
  parameter DW = 16, // Divisor width
  parameter CW = 6 // Bit counter width
)(
  input wire clk, // System clock
  input wire rst_b, // Asynchronous reset, active low
  input wire start, // Load operands, one cycle
  input wire [NW-1:0] num, // Dividend
  input wire [DW-1:0] den, // Divisor, nonzero
  output wire busy, // High while dividing
  output reg [NW-1:0] quot // Quotient, stable when idle
);

  reg [DW:0] rem;
  reg [CW-1:0] cnt;
  wire [DW:0] sh = {rem[DW-1:0], quot[NW-1]};
  wire ge = (sh >= {1'b0, den});

  assign busy = (cnt != {CW{1'b0}});

  // ****************************************
  // Restoring division, one bit a cycle
  // ****************************************
  // Slow but tiny; the command samples arrive far apart
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      quot <= {NW{1'b0}};
      rem <= {(DW+1){1'b0}};
      cnt <= {CW{1'b0}};
    end
    else if (start)
    begin
      quot <= num;
      rem <= {(DW+1){1'b0}};
      cnt <= NW[CW-1:0];
    end
    else if (busy)
    begin
      rem <= ge ? sh - {1'b0, den} : sh;
      quot <= {quot[NW-2:0], ge};
      cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

// >>> hdl/setpoint_cond.v
`include "cond_regs.vh"
`default_nettype none

module setpoint_cond #(
  parameter [31:0] RAMP_UNIT_CYC = `RAMP_UNIT_NS / `CLK_NS // Cycles per 0.1 s
)(
  input wire MCLK, // System clock
  input wire RST_B, // Async reset, active low
  input wire [7:0] ADDR, // Register address
  input wire [15:0] WDATA, // Write data
  input wire WR, // Write strobe
  input wire RD, // Read strobe
  output reg [15:0] RDATA, // Read data, cycle after RD
  input wire ADC_VALID, // Sample strobe
  input wire [15:0] ADC_DATA, // Signed sample, mV or uA
  input wire [15:0] SUPPLY_MV, // Supply voltage in mV
  input wire DOUBLE_COIL, // High on two-coil builds
  output reg signed [15:0] SETPOINT, // 16384 is full scale
  output reg COIL_OFF, // Coil current cut
  output reg IN_ERROR, // Input error present
  output wire IRQ // Level interrupt
);

  localparam ST_IDLE = 2'b00;
  localparam ST_DIV = 2'b01;
  localparam ST_OUT = 2'b10;

  integer k;
  integer m;
  reg [`CFG_MSB:0] cfg;
  reg [`CFG_MSB:0] cfg_s;
  reg [15:0] dband;
  reg [15:0] dband_s;
  reg [10:0] gain;
  reg [10:0] gain_s;
  reg signed [15:0] offs;
  reg signed [15:0] offs_s;
  reg [8:0] rtime [0:3];
  reg [8:0] rtime_s [0:3];
  reg signed [15:0] bx [0:`NBP-1];
  reg signed [15:0] bx_s [0:`NBP-1];
  reg signed [15:0] by [0:`NBP-1];
  reg signed [15:0] by_s [0:`NBP-1];
  reg pending;
  reg init;
  reg [1:0] st;
  reg div_start;
  reg signed [21:0] lbase_l;
  reg neg_l;
  reg r_now;
  reg c_now;
  reg r_err;
  reg c_err;
  reg signed [15:0] target;
  reg [31:0] racc;
  reg [`IRQ_W-1:0] istat;
  reg [`IRQ_W-1:0] imask;
  reg [3:0] seg;
  reg [38:0] dnum_l;
  reg [15:0] den_l;

  // Range table: centre, span, 2^30 / span
  function [51:0] range_of;
    input [3:0] t;
    input [15:0] mid;
    begin
      case (t)
        `T_0_20MA: range_of = {`U10K, `U10K, `R10K};
        `T_4_20MA: range_of = {`U12K, `U8K, `R8K};
        `T_PM10MA: range_of = {16'h0000, `U10K, `R10K};
        `T_0_10V: range_of = {`U5K, `U5K, `R5K};
        `T_PM10V: range_of = {16'h0000, `U10K, `R10K};
        `T_RAT10: range_of = {mid, `U10K, `R10K};
        `T_RAT5: range_of = {mid, `U5K, `R5K};
        `T_0_5V: range_of = {`U2K5, `U2K5, `R2K5};
        default: range_of = {16'h0000, `U10K, `R10K};
      endcase
    end
  endfunction

  // Identity curve point for index i
  function [15:0] bp_def;
    input [3:0] i;
    begin
      bp_def = `BP_FIRST + {i, 12'h000};
    end
  endfunction

  // ****************************************
  // Register writes
  // ****************************************
  wire [3:0] bi = ADDR[5:2];
  wire bi_ok = (bi < `NBP);
  wire save = WR && (ADDR == `A_CTRL) && WDATA[`CTRL_SAVE];
  wire [8:0] tclamp = (WDATA > `RAMP_MAX) ? `RAMP_MAX : WDATA[8:0];

  // Edits other than the interrupt mask go to the shadow set; save copies it to the live set
  always @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cfg_s <= `CFG_RST;
      cfg <= `CFG_RST;
      dband_s <= 16'h0000;
      dband <= 16'h0000;
      gain_s <= `GAIN_RST;
      gain <= `GAIN_RST;
      offs_s <= 16'h0000;
      offs <= 16'h0000;
      pending <= 1'b0;
      init <= 1'b0;
      imask <= {`IRQ_W{1'b0}};
      for (k = 0; k < 4; k = k + 1)
      begin
        rtime_s[k] <= 9'h000;
        rtime[k] <= 9'h000;
      end
      for (k = 0; k < `NBP; k = k + 1)
      begin
        bx_s[k] <= bp_def(k[3:0]);
        bx[k] <= bp_def(k[3:0]);
        by_s[k] <= bp_def(k[3:0]);
        by[k] <= bp_def(k[3:0]);
      end
    end
    else
    begin
      init <= 1'b1;
      // Strap is read once, after reset is gone
      if (!init && !DOUBLE_COIL)
      begin
        cfg_s[`TYPE_MSB:0] <= `T_0_10V;
        cfg[`TYPE_MSB:0] <= `T_0_10V;
      end
      if (WR && (ADDR != `A_CTRL) && (ADDR != `A_ISTAT) && (ADDR != `A_IMASK))
        pending <= 1'b1;
      if (WR)
      begin
        case (ADDR)
          `A_CFG: cfg_s <= WDATA[`CFG_MSB:0];
          `A_DBAND: dband_s <= WDATA;
          `A_GAIN: gain_s <= WDATA[10:0];
          `A_OFFS: offs_s <= WDATA;
          `A_RISE_P: rtime_s[0] <= tclamp;
          `A_FALL_P: rtime_s[1] <= tclamp;
          `A_RISE_N: rtime_s[2] <= tclamp;
          `A_FALL_N: rtime_s[3] <= tclamp;
          `A_IMASK: imask <= WDATA[`IRQ_W-1:0];
          default:
          begin
            if (ADDR[7:6] == `BPX_PAGE && bi_ok)
              bx_s[bi] <= WDATA;
            else if (ADDR[7:6] == `BPY_PAGE && bi_ok)
              by_s[bi] <= WDATA;
          end
        endcase
      end
      if (save)
      begin
        cfg <= cfg_s;
        dband <= dband_s;
        gain <= gain_s;
        offs <= offs_s;
        pending <= 1'b0;
        for (k = 0; k < 4; k = k + 1)
          rtime[k] <= rtime_s[k];
        for (k = 0; k < `NBP; k = k + 1)
        begin
          bx[k] <= bx_s[k];
          by[k] <= by_s[k];
        end
      end
    end
  end

  // ****************************************
  // Normalise, invert, dead band
  // ****************************************
  wire [3:0] ityp = cfg[`TYPE_MSB:0];
  wire [51:0] rng = range_of(ityp, SUPPLY_MV >> 1);
  wire bipolar = (ityp == `T_PM10MA) || (ityp == `T_PM10V);
  wire ratio = (ityp == `T_RAT10) || (ityp == `T_RAT5);
  // One coil: offset types run from their low end upward
  wire single_off = !DOUBLE_COIL && !bipolar;
  wire signed [17:0] ctr = $signed({2'b00, rng[51:36]});
  wire signed [17:0] base = single_off ? ctr - $signed({2'b00, rng[35:20]}) : ctr;
  // Centre off raw zero gives motion at zero input
  wire signed [17:0] diff = $signed({{2{ADC_DATA[15]}}, ADC_DATA}) - base;
  // Round to nearest: the truncated reciprocal would leave exact points one LSB low
  wire signed [38:0] prod = diff * $signed({1'b0, rng[19:0]}) + (`RND_HALF << single_off);
  wire signed [21:0] norm = single_off ? prod[38:17] : prod[37:16];

  // Error checks on the sample
  wire c_bad = (ityp > `T_LAST) || (ratio && (SUPPLY_MV == 16'h0000));
  wire r_bad = (norm > `FS + `TOL) || (norm < -(`FS + `TOL)) || (single_off && (norm < -`TOL));

  wire signed [21:0] xs = (norm > `FS) ? `FS : (norm < -`FS) ? -`FS : norm;
  // Inversion is ignored for offset types on one coil
  wire inv = cfg[`CFG_INV] && (DOUBLE_COIL || bipolar);
  wire signed [21:0] x1 = inv ? -xs : xs;
  wire [21:0] mag = x1[21] ? -x1 : x1;
  wire signed [21:0] x2 = (mag <= {6'h00, dband}) ? 22'sh000000 : x1;

  // ****************************************
  // Piecewise-linear curve
  // ****************************************
  // Highest segment whose left point is not above the input
  always @*
  begin
    seg = 4'h0;
    for (m = 1; m < `NBP - 1; m = m + 1)
      if (x2 >= bx[m])
        seg = m[3:0];
  end

  wire [3:0] seg_n = seg + 4'h1;
  wire lin_on = cfg[`CFG_LIN];
  wire below = (x2 <= bx[0]);
  wire above = (x2 >= bx[`NBP-1]);
  wire signed [21:0] dx = x2 - bx[seg];
  wire signed [16:0] dy = by[seg_n] - by[seg];
  wire signed [16:0] dxb = bx[seg_n] - bx[seg];
  // Badly ordered points give a flat segment, not a divide by zero
  wire flat = !lin_on || below || above || (dxb <= 17'sh00000);
  wire signed [38:0] dmul = dx * dy;
  wire [38:0] dnum = dmul[38] ? -dmul : dmul;
  wire signed [21:0] lbase = !lin_on ? x2 : below ? by[0] : above ? by[`NBP-1] : by[seg];
  wire div_busy;
  wire [38:0] quot;

  seg_divider #(
    .NW(39),
    .DW(16),
    .CW(6)
  ) u_div (
    .clk(MCLK),
    .rst_b(RST_B),
    .start(div_start),
    .num(dnum_l),
    .den(den_l),
    .busy(div_busy),
    .quot(quot)
  );

  // ****************************************
  // Gain, offset, saturation
  // ****************************************
  wire signed [21:0] ylin = neg_l ? lbase_l - $signed(quot[21:0]) : lbase_l + $signed(quot[21:0]);
  // Zero gain is not allowed; it acts as the smallest step
  wire [10:0] g = (gain == 11'h000) ? 11'h001 : gain;
  wire signed [33:0] yg_full = ylin * $signed({1'b0, g});
  wire signed [33:0] ygs = yg_full >>> `GAIN_FRAC;
  wire signed [21:0] yg = ygs[21:0];
  // Offset pushes both halves away from zero
  wire signed [21:0] yo = (yg > 0) ? yg + offs : (yg < 0) ? yg - offs : 22'sh000000;
  wire signed [21:0] lo_lim = DOUBLE_COIL ? -`FS : 22'sh000000;
  wire signed [21:0] ysat = (yo > `FS) ? `FS : (yo < lo_lim) ? lo_lim : yo;

  // Sample pipeline; samples during a division are dropped
  always @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st <= ST_IDLE;
      div_start <= 1'b0;
      lbase_l <= 22'sh000000;
      neg_l <= 1'b0;
      r_now <= 1'b0;
      c_now <= 1'b0;
      r_err <= 1'b0;
      c_err <= 1'b0;
      dnum_l <= 39'h0000000000;
      den_l <= 16'h0001;
      target <= 16'h0000;
      COIL_OFF <= 1'b0;
      IN_ERROR <= 1'b0;
    end
    else
    begin
      div_start <= 1'b0;
      case (st)
        ST_IDLE:
        begin
          if (ADC_VALID)
          begin
            r_now <= r_bad;
            c_now <= c_bad;
            lbase_l <= lbase;
            neg_l <= !flat && dmul[38];
            // Operands caught with the strobe; the sample word is not held after it
            dnum_l <= flat ? 39'h0000000000 : dnum;
            den_l <= flat ? 16'h0001 : dxb[15:0];
            div_start <= 1'b1;
            st <= ST_DIV;
          end
        end
        ST_DIV:
        begin
          if (!div_start && !div_busy)
            st <= ST_OUT;
        end
        ST_OUT:
        begin
          st <= ST_IDLE;
          r_err <= r_now;
          c_err <= c_now;
          IN_ERROR <= r_now || c_now;
          COIL_OFF <= r_now && cfg[`CFG_SHUT];
          // Range error keeps the last good target
          if (c_now)
            target <= 16'h0000;
          else if (!r_now)
            target <= ysat[15:0];
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Ramp
  // ****************************************
  wire pos_half = (SETPOINT > 0) || ((SETPOINT == 0) && (target > 0));
  wire to_zero = pos_half ? (target < SETPOINT) : (target > SETPOINT);
  wire [1:0] ridx = {!pos_half, to_zero};
  wire [31:0] period = rtime[ridx] * RAMP_UNIT_CYC;
  wire [32:0] racc_n = {1'b0, racc} + `RSTEP;

  // Full scale in one period: one step per period/16384 cycles
  always @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      SETPOINT <= 16'h0000;
      racc <= 32'h00000000;
    end
    else if (COIL_OFF)
    begin
      SETPOINT <= 16'h0000;
      racc <= 32'h00000000;
    end
    else if (SETPOINT == target)
      racc <= 32'h00000000;
    else if (period == 32'h00000000)
      SETPOINT <= target;
    else if (racc_n >= {1'b0, period})
    begin
      SETPOINT <= (target > SETPOINT) ? SETPOINT + 16'h0001 : SETPOINT - 16'h0001;
      racc <= racc_n[31:0] - period;
    end
    else
      racc <= racc_n[31:0];
  end

  // ****************************************
  // Interrupts and read-back
  // ****************************************
  wire out_st = (st == ST_OUT);
  wire [`IRQ_W-1:0] ev = {save, out_st && c_now && !c_err, out_st && r_now && !r_err};
  wire [`IRQ_W-1:0] iclr = (WR && (ADDR == `A_ISTAT)) ? WDATA[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

  // A new event beats a clear in the same cycle
  always @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      istat <= {`IRQ_W{1'b0}};
    else
      istat <= (istat & ~iclr) | ev;
  end

  assign IRQ = |(istat & imask);

  // Read data for one cycle, zero otherwise
  always @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      RDATA <= 16'h0000;
    else if (!RD)
      RDATA <= 16'h0000;
    else
    begin
      case (ADDR)
        `A_CFG: RDATA <= {9'h000, cfg_s};
        `A_DBAND: RDATA <= dband_s;
        `A_GAIN: RDATA <= {5'h00, gain_s};
        `A_OFFS: RDATA <= offs_s;
        `A_RISE_P: RDATA <= {7'h00, rtime_s[0]};
        `A_FALL_P: RDATA <= {7'h00, rtime_s[1]};
        `A_RISE_N: RDATA <= {7'h00, rtime_s[2]};
        `A_FALL_N: RDATA <= {7'h00, rtime_s[3]};
        `A_STAT: RDATA <= {8'h00, pending, COIL_OFF, c_err, r_err, ityp};
        `A_ISTAT: RDATA <= {13'h0000, istat};
        `A_IMASK: RDATA <= {13'h0000, imask};
        `A_SETP: RDATA <= SETPOINT;
        `A_NORM: RDATA <= x2[15:0];
        default:
        begin
          if (ADDR[7:6] == `BPX_PAGE && bi_ok)
            RDATA <= bx_s[bi];
          else if (ADDR[7:6] == `BPY_PAGE && bi_ok)
            RDATA <= by_s[bi];
          else
            RDATA <= 16'h0000;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> dv/adc_source.sv
`default_nettype none
module adc_source (
  input wire logic clk, // System clock
  input wire logic go, // Convert one sample
  input wire logic [15:0] level, // Level in mV or uA
  output var logic valid, // One-cycle sample strobe
  output var logic [15:0] data // Sample word, meaningful only with valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // Word is inverted outside its strobe so a stale value never passes for a sample
  always @(posedge clk)
  begin
    valid <= go;
    data <= go ? level : ~data;
  end
  // Quiet converter at time zero
  initial
  begin
    valid = 1'b0;
    data = 16'h0000;
  end
endmodule
`default_nettype wire

// >>> dv/setpoint_cond_chk.sv
`default_nettype none
module setpoint_cond_chk (
  input wire logic MCLK, // System clock
  input wire logic RST_B, // Reset, active low
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  input wire logic ADC_VALID, // Sample strobe
  input wire logic DOUBLE_COIL, // Two-coil strap
  input wire logic [15:0] RDATA, // Read data
  input wire logic signed [15:0] SETPOINT, // Conditioned setpoint
  input wire logic COIL_OFF, // Coil current cut
  input wire logic IN_ERROR, // Input error
  input wire logic IRQ // Level interrupt
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // Read data stand only in the slot after a read
  chk_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data outside read slot");
  // Cutting the coil is only a reaction to an input error
  chk_off_err: assert property (COIL_OFF |-> IN_ERROR)
    else $error("coil cut without input error");
  chk_off_zero: assert property (COIL_OFF && $past(COIL_OFF) |-> SETPOINT == 16'sh0000)
    else $error("setpoint not zero while coil cut");
  // Flags move only when a processed sample completes
  chk_err_time: assert property ($changed(IN_ERROR) |-> $past(ADC_VALID, 43))
    else $error("error flag moved without a sample");
  chk_off_time: assert property ($changed(COIL_OFF) |-> $past(ADC_VALID, 43))
    else $error("coil cut moved without a sample");
  // Interrupt rises from a write or a finished sample, falls only from a write
  chk_irq_rise: assert property ($rose(IRQ) |-> $past(WR) || $past(WR, 2)
    || $past(ADC_VALID, 43))
    else $error("interrupt rose without cause");
  chk_irq_fall: assert property ($fell(IRQ) |-> $past(WR) || $past(WR, 2))
    else $error("interrupt fell without a write");
  // Output never leaves full scale
  chk_sat_range: assert property (SETPOINT <= 16'sh4000 && SETPOINT >= -16'sh4000)
    else $error("setpoint beyond full scale");
  chk_single_pos: assert property (!DOUBLE_COIL |-> !SETPOINT[15])
    else $error("negative setpoint on single coil");
endmodule
bind setpoint_cond setpoint_cond_chk u_chk (.MCLK(MCLK), .RST_B(RST_B), .WR(WR), .RD(RD),
  .ADC_VALID(ADC_VALID), .DOUBLE_COIL(DOUBLE_COIL), .RDATA(RDATA), .SETPOINT(SETPOINT),
  .COIL_OFF(COIL_OFF), .IN_ERROR(IN_ERROR), .IRQ(IRQ));
`default_nettype wire

// >>> dv/command_setpoint_conditioning_bench.sv
`include "cond_regs.vh"
`default_nettype none
module command_setpoint_conditioning_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RU = 64; // Short ramp unit: a 256 setting gives one LSB per cycle
  logic MCLK = 1'b0;
  logic RST_B = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [15:0] SUPPLY_MV = 16'h5DC0; // 24 V supply, centre 12 V
  logic DOUBLE_COIL = 1'b1;
  logic go = 1'b0;
  logic [15:0] lvl = 16'h0000;
  logic [15:0] RDATA;
  logic ADC_VALID;
  logic [15:0] ADC_DATA;
  logic signed [15:0] SETPOINT;
  logic COIL_OFF;
  logic IN_ERROR;
  logic IRQ;
  int failures = 0;
  int compares = 0;
  logic [15:0] raws [0:7] = '{16'h0000, 16'h3E80, 16'h1388, 16'h0000, 16'h1388, 16'h4268, 16'h38A4, 16'h0EA6};
  logic [15:0] exps [0:7] = '{16'hC000, 16'h2000, 16'h2000, 16'hC000, 16'h2000, 16'h2000, 16'h2000, 16'h2000};
  // 10 MHz clock
  always #50 MCLK = ~MCLK;
  setpoint_cond #(.RAMP_UNIT_CYC(RU)) dut (.MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .ADC_VALID(ADC_VALID), .ADC_DATA(ADC_DATA), .SUPPLY_MV(SUPPLY_MV),
    .DOUBLE_COIL(DOUBLE_COIL), .SETPOINT(SETPOINT), .COIL_OFF(COIL_OFF), .IN_ERROR(IN_ERROR), .IRQ(IRQ));
  adc_source src (.clk(MCLK), .go(go), .level(lvl), .valid(ADC_VALID), .data(ADC_DATA));
  // Bus and sample tasks
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
    // Look at outputs only once the written value has settled
    @(negedge MCLK);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    chk(RDATA, exp);
  endtask
  // Waits past the 45-cycle path so each sample is taken, never dropped
  task automatic smp(input logic [15:0] v);
    @(posedge MCLK);
    lvl <= v;
    go <= 1'b1;
    @(posedge MCLK);
    go <= 1'b0;
    repeat (48) @(posedge MCLK);
    @(negedge MCLK);
  endtask
  task automatic near(input logic [15:0] got, input int exp);
    int d;
    d = int'($signed(got)) - exp;
    compares++;
    if ($isunknown(got) || d > 32 || d < -32)
    begin
      failures++;
      $display("[ERR] %0t: setpoint %0d not near %0d", $time, $signed(got), exp);
    end
  endtask
  task automatic save(input logic [15:0] cfg);
    wr(`A_CFG, cfg);
    wr(`A_CTRL, 16'h0001);
  endtask
  task automatic do_reset(input logic dc);
    @(posedge MCLK);
    RST_B <= 1'b0;
    DOUBLE_COIL <= dc;
    repeat (5) @(posedge MCLK);
    RST_B <= 1'b1;
    repeat (2) @(posedge MCLK);
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    do_reset(1'b1);
    rd(`A_CFG, 16'h0004);
    rd(`A_GAIN, 16'h0100);
    rd(8'h3C, 16'h0000);
    wr(`A_RISE_P, 16'h0FFF);
    rd(`A_RISE_P, 16'h01C2);
    wr(`A_RISE_P, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      save({12'h000, 4'(i)});
      smp(raws[i]);
      chk(SETPOINT, exps[i]);
    end
    save(16'h0008);
    smp(16'h1388);
    chk(SETPOINT, 16'h0000);
    chk({15'h0000, IN_ERROR}, 16'h0001);
    save(16'h0004);
    wr(`A_ISTAT, 16'h0007);
    wr(`A_IMASK, 16'h0004);
    chk({15'h0000, IRQ}, 16'h0000);
    wr(`A_CFG, 16'h0014);
    smp(16'h1388);
    chk(SETPOINT, 16'h2000);
    rd(`A_STAT, 16'h0084);
    wr(`A_CTRL, 16'h0001);
    rd(`A_ISTAT, 16'h0004);
    chk({15'h0000, IRQ}, 16'h0001);
    wr(`A_ISTAT, 16'h0004);
    rd(`A_ISTAT, 16'h0000);
    chk({15'h0000, IRQ}, 16'h0000);
    smp(16'h1388);
    chk(SETPOINT, 16'hE000);
    wr(`A_DBAND, 16'h1000);
    save(16'h0004);
    smp(16'h07D0);
    chk(SETPOINT, 16'h0000);
    rd(`A_NORM, 16'h0000);
    smp(16'hF830);
    chk(SETPOINT, 16'h0000);
    wr(`A_DBAND, 16'h0000);
    wr(`A_GAIN, 16'h0200);
    wr(`A_OFFS, 16'h0400);
    save(16'h0004);
    smp(16'h09C4);
    chk(SETPOINT, 16'h2400);
    smp(16'hF63C);
    chk(SETPOINT, 16'hDC00);
    wr(`A_GAIN, 16'h0400);
    wr(`A_OFFS, 16'h0000);
    save(16'h0004);
    smp(16'h1388);
    chk(SETPOINT, 16'h4000);
    wr(`A_GAIN, 16'h0100);
    wr(8'h94, 16'h2000);
    save(16'h0024);
    smp(16'h04E2);
    chk(SETPOINT, 16'h1000);
    smp(16'h09C4);
    chk(SETPOINT, 16'h2000);
    save(16'h0004);
    smp(16'h1388);
    smp(16'h2AF8);
    chk(SETPOINT, 16'h2000);
    chk({14'h0000, COIL_OFF, IN_ERROR}, 16'h0001);
    rd(`A_ISTAT, 16'h0005);
    save(16'h0044);
    smp(16'h2AF8);
    chk({SETPOINT[13:0], COIL_OFF, IN_ERROR}, 16'h0003);
    smp(16'h1388);
    chk({SETPOINT[13:0], COIL_OFF, IN_ERROR}, 16'h8000);
    wr(`A_RISE_P, 16'h0100);
    wr(`A_FALL_N, 16'h0100);
    save(16'h0004);
    smp(16'h0000);
    chk(SETPOINT, 16'h0000);
    smp(16'h1388);
    repeat (4000) @(posedge MCLK);
    @(negedge MCLK);
    near(SETPOINT, 4005);
    repeat (4300) @(posedge MCLK);
    chk(SETPOINT, 16'h2000);
    smp(16'hEC78);
    chk(SETPOINT, 16'hE000);
    smp(16'h0000);
    repeat (4000) @(posedge MCLK);
    @(negedge MCLK);
    near(SETPOINT, -4187);
    do_reset(1'b0);
    rd(`A_CFG, 16'h0003);
    save(16'h0013);
    smp(16'h1388);
    chk(SETPOINT, 16'h2000);
    smp(16'hFC18);
    chk({15'h0000, IN_ERROR}, 16'h0001);
    results;
  end
  // Watchdog well beyond the expected run of about 14000 cycles
  initial
  begin
    #5000000;
    failures++;
    $display("[ERR] %0t: watchdog expired", $time);
    results;
  end
endmodule
`default_nettype wire
